// File: verilog/epoc_pkg.sv
// constants, field layouts and carrier types for the enhanced pwm output control
// assumes a single 125 MHz instruction-cycle clock and a plain register port
package epoc_pkg;
  // register word offsets, chosen on a plain 4-byte aligned map
  localparam logic [7:0] OFF_SHUTDOWN = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_STEER = 8'h08;
  localparam logic [7:0] OFF_TIMEBASE = 8'h0c;
  localparam logic [7:0] OFF_MODE = 8'h10;
  // reset values
  localparam logic [7:0] RST_SHUTDOWN = 8'h00;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [7:0] RST_STEER = 8'h01;
  localparam logic [7:0] RST_TIMEBASE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  // field positions
  localparam int FLAG_BIT = 7;
  localparam int SRC_LSB = 4;
  localparam int AC_LSB = 2;
  localparam int BD_LSB = 0;
  localparam int RESTART_BIT = 7;
  localparam int CMPL_LSB = 6;
  localparam int SYNC_BIT = 4;
  localparam int TSEL1_BIT = 0;
  localparam int TSEL2_BIT = 3;
  localparam int TSEL3_BIT = 6;
  localparam int BRIDGE_LSB = 6;
  localparam logic [7:0] STEER_MASK = 8'hdf;
  localparam logic [7:0] TIMEBASE_MASK = 8'h49;
  localparam logic [1:0] PWM_MODE_HI = 2'h3;
  localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
  localparam logic [1:0] BRIDGE_FWD = 2'h1;
  localparam logic [1:0] BRIDGE_HALF = 2'h2;
  localparam logic [1:0] BRIDGE_REV = 2'h3;

  typedef struct packed {
    logic flag;
    logic [2:0] src;
    logic [1:0] ac_state;
    logic [1:0] bd_state;
  } epoc_shutdown_t;

  typedef struct packed {
    logic [3:0] dat;
    logic [3:0] oe_n;
  } epoc_pins_t;

  typedef enum logic [1:0] {EPOC_RUN, EPOC_SHUT, EPOC_WAIT} epoc_state_t;
endpackage

// File: verilog/epoc_top.sv
// enhanced pwm output control: shutdown, delay, steering, timebase select
// assumes raw pwm, period start and timer pulses come from the pwm core on mclk
// Behaviour
// RULE1 - shutdown event sets flag, outputs to shutdown
// RULE2 - source field picks comparator/fault trigger
// RULE3 - pair a/c shutdown: tristate, high, low
// RULE4 - pair b/d shutdown: tristate, high, low
// RULE5 - trigger is level, shutdown persists
// RULE6 - flag writes ignored while condition present
// RULE7 - resume only at next period start
// RULE8 - auto restart clears flag itself
// RULE9 - manual restart needs software flag clear
// RULE10 - delay count cycles before active edge
// RULE11 - complementary pair selection
// RULE12 - steering sync at period or immediate
// RULE13 - steer enables route pwm with polarity
// RULE14 - steering only in pwm single mode
// RULE15 - timer select picks fourth or second
// RULE16 - timebase bits at 6, 3, 0
// RULE17 - mode bits set pair polarity
// RULE18 - bridge field selects output topology
// RULE19 - shutdown drive from first flag cycle
// RULE20 - fault and comparators synchronised first
`timescale 1ns/1ps
module epoc_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pwm core
  input wire logic pwm_raw,
  input wire logic period_start,
  input wire logic second_timer_tick,
  input wire logic fourth_timer_tick,
  output logic [2:0] pwm_timebase_tick,
  // port latch values for unsteered pins
  input wire logic [3:0] port_dat,
  // shutdown sources
  input wire logic fault_input_pin_n,
  input wire logic comparator1_output,
  input wire logic comparator2_output,
  // pins a..d, bit0 = a
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_out_oe_n
);
  epoc_pkg::epoc_shutdown_t sd_ff;
  logic [7:0] delay_ff;
  logic [7:0] steer_ff;
  logic [7:0] steer_act_ff;
  logic [7:0] tbase_ff;
  logic [7:0] mode_ff;
  logic [7:0] rdata_ff;
  logic flt_level;
  logic c1_hi;
  logic c2_hi;
  epoc_pkg::epoc_state_t state_ff;
  epoc_pkg::epoc_state_t nxt_state;
  logic [6:0] dly_cnt_ff;
  logic pwm_dly_ff;
  logic pwm_prev_ff;
  epoc_pkg::epoc_pins_t pins_ff;
  epoc_pkg::epoc_pins_t nxt_pins;

  // RULE20 three stage sync per source pin
  // fault pin idles high so reset does not fake a fault
  epoc_sync3 #(
    .INIT(1'b1)
  ) flt_sync_u (
    .mclk(mclk),
    .reset(reset),
    .pin_in(fault_input_pin_n),
    .level(flt_level)
  );
  epoc_sync3 #(
    .INIT(1'b0)
  ) c1_sync_u (
    .mclk(mclk),
    .reset(reset),
    .pin_in(comparator1_output),
    .level(c1_hi)
  );
  epoc_sync3 #(
    .INIT(1'b0)
  ) c2_sync_u (
    .mclk(mclk),
    .reset(reset),
    .pin_in(comparator2_output),
    .level(c2_hi)
  );

  // RULE2 source select
  wire [2:0] src = sd_ff.src;
  wire cmp_term = (src[1:0] == 2'h1) ? c1_hi :
                  (src[1:0] == 2'h2) ? c2_hi :
                  (src[1:0] == 2'h3) ? (c1_hi | c2_hi) : 1'b0;
  // RULE5 level, not edge
  wire shut_cond = cmp_term | (src[2] & ~flt_level);

  // register decode
  wire sel_sd = reg_addr == epoc_pkg::OFF_SHUTDOWN;
  wire sel_dl = reg_addr == epoc_pkg::OFF_DELAY;
  wire sel_st = reg_addr == epoc_pkg::OFF_STEER;
  wire sel_tb = reg_addr == epoc_pkg::OFF_TIMEBASE;
  wire sel_md = reg_addr == epoc_pkg::OFF_MODE;
  wire wr_sd = reg_wr & sel_sd;
  wire auto_rs = delay_ff[epoc_pkg::RESTART_BIT];
  // RULE6 flag write blocked while condition stands
  wire flag_wr_ok = wr_sd & ~shut_cond;
  // RULE8 auto clear once condition gone
  wire auto_clr = auto_rs & ~shut_cond;
  // RULE1 set wins over any clear
  wire nxt_flag = shut_cond ? 1'b1 :
                  flag_wr_ok ? reg_wdata[epoc_pkg::FLAG_BIT] :
                  auto_clr ? 1'b0 : sd_ff.flag;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sd_ff <= epoc_pkg::RST_SHUTDOWN;
      delay_ff <= epoc_pkg::RST_DELAY;
      steer_ff <= epoc_pkg::RST_STEER;
      tbase_ff <= epoc_pkg::RST_TIMEBASE;
      mode_ff <= epoc_pkg::RST_MODE;
    end
    else
    begin
      sd_ff.flag <= nxt_flag;
      if (wr_sd)
        sd_ff[6:0] <= reg_wdata[6:0];
      if (reg_wr & sel_dl)
        delay_ff <= reg_wdata;
      if (reg_wr & sel_st)
        steer_ff <= reg_wdata & epoc_pkg::STEER_MASK;
      // RULE16 only bits 6, 3, 0 stored
      if (reg_wr & sel_tb)
        tbase_ff <= reg_wdata & epoc_pkg::TIMEBASE_MASK;
      if (reg_wr & sel_md)
        mode_ff <= reg_wdata;
    end
  end

  wire [7:0] rd_mux = sel_sd ? sd_ff :
                      sel_dl ? delay_ff :
                      sel_st ? steer_ff :
                      sel_tb ? tbase_ff :
                      sel_md ? mode_ff : 8'h00;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      rdata_ff <= rd_mux;
    else
      rdata_ff <= 8'h00;
  end
  assign reg_rdata = rdata_ff;

  // RULE15 per-module time base, third timer stays capture base outside
  epoc_tbsel tbsel1_u (
    .use_fourth(tbase_ff[epoc_pkg::TSEL1_BIT]),
    .second_tick(second_timer_tick),
    .fourth_tick(fourth_timer_tick),
    .tick(pwm_timebase_tick[0])
  );
  epoc_tbsel tbsel2_u (
    .use_fourth(tbase_ff[epoc_pkg::TSEL2_BIT]),
    .second_tick(second_timer_tick),
    .fourth_tick(fourth_timer_tick),
    .tick(pwm_timebase_tick[1])
  );
  epoc_tbsel tbsel3_u (
    .use_fourth(tbase_ff[epoc_pkg::TSEL3_BIT]),
    .second_tick(second_timer_tick),
    .fourth_tick(fourth_timer_tick),
    .tick(pwm_timebase_tick[2])
  );

  // RULE12 steering takes effect now or at period start
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      steer_act_ff <= epoc_pkg::RST_STEER;
    else if (~steer_ff[epoc_pkg::SYNC_BIT] | period_start)
      steer_act_ff <= steer_ff;
  end

  // restart sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      epoc_pkg::EPOC_RUN:
        if (nxt_flag)
          nxt_state = epoc_pkg::EPOC_SHUT;
      // RULE9 without auto restart only a software clear leaves here
      epoc_pkg::EPOC_SHUT:
        if (~nxt_flag)
          nxt_state = epoc_pkg::EPOC_WAIT;
      // RULE7 hold off until next period begins
      epoc_pkg::EPOC_WAIT:
        if (nxt_flag)
          nxt_state = epoc_pkg::EPOC_SHUT;
        else if (period_start)
          nxt_state = epoc_pkg::EPOC_RUN;
      default:
        nxt_state = epoc_pkg::EPOC_RUN;
    endcase
  end

  // RULE10 rising edge delayed by count, falling edge passes at once
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= epoc_pkg::EPOC_RUN;
      dly_cnt_ff <= 7'h00;
      pwm_dly_ff <= 1'b0;
      pwm_prev_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pwm_prev_ff <= pwm_raw;
      if (~pwm_raw)
      begin
        pwm_dly_ff <= 1'b0;
        dly_cnt_ff <= 7'h00;
      end
      else if (~pwm_prev_ff)
      begin
        dly_cnt_ff <= delay_ff[6:0];
        pwm_dly_ff <= delay_ff[6:0] == 7'h00;
      end
      else if (dly_cnt_ff > 7'h01)
        dly_cnt_ff <= dly_cnt_ff - 7'h01;
      else
        pwm_dly_ff <= 1'b1;
    end
  end

  // RULE17 polarity per pair from mode low bits
  wire [1:0] bridge = mode_ff[7:6];
  wire pwm_mode = mode_ff[3:2] == epoc_pkg::PWM_MODE_HI;
  wire ac_act = pwm_dly_ff ^ mode_ff[1];
  wire bd_act = pwm_dly_ff ^ mode_ff[0];
  wire ac_inact = mode_ff[1];
  wire bd_inact = mode_ff[0];
  // RULE11 complementary partner of a
  wire [1:0] cmpl = steer_act_ff[7:6];
  wire [3:0] pair_route = (cmpl == 2'h1) ? 4'h3 :
                          (cmpl == 2'h2) ? 4'h5 :
                          (cmpl == 2'h3) ? 4'h9 : steer_act_ff[3:0];
  wire [3:0] comp_inv = (cmpl == 2'h0) ? 4'h0 : {pair_route[3:1], 1'b0};
  wire [3:0] act_pol = {bd_act, ac_act, bd_act, ac_act};
  wire [3:0] inact_pol = {bd_inact, ac_inact, bd_inact, ac_inact};
  // RULE14 steering only in pwm single output
  wire steer_on = pwm_mode & (bridge == epoc_pkg::BRIDGE_SINGLE);

  always_comb
  begin
    nxt_pins.dat = port_dat;
    nxt_pins.oe_n = 4'hf;
    // RULE18 bridge topology
    if (pwm_mode)
    begin
      case (bridge)
        epoc_pkg::BRIDGE_SINGLE:
        begin
          // RULE13 steered pins carry pwm, others port
          nxt_pins.dat = (pair_route & (act_pol ^ comp_inv)) | (~pair_route & port_dat);
          nxt_pins.oe_n = ~pair_route;
        end
        epoc_pkg::BRIDGE_FWD:
        begin
          nxt_pins.dat = {bd_act, ac_inact, bd_inact, ~ac_inact};
          nxt_pins.oe_n = 4'h0;
        end
        epoc_pkg::BRIDGE_HALF:
        begin
          nxt_pins.dat = {port_dat[3:2], ~bd_act, ac_act};
          nxt_pins.oe_n = 4'hc;
        end
        epoc_pkg::BRIDGE_REV:
        begin
          nxt_pins.dat = {bd_inact, ~ac_inact, bd_act, ac_inact};
          nxt_pins.oe_n = 4'h0;
        end
        default:
        begin
          nxt_pins.dat = port_dat;
          nxt_pins.oe_n = 4'hf;
        end
      endcase
    end
    else
    begin
      nxt_pins.dat = port_dat;
      nxt_pins.oe_n = 4'hf;
    end
    if (~steer_on)
      nxt_pins.oe_n = nxt_pins.oe_n;
    // RULE1 shutdown overrides everything while flag set or waiting
    if (nxt_flag | (state_ff != epoc_pkg::EPOC_RUN))
    begin
      // RULE3 pair a/c drive state
      nxt_pins.dat[0] = sd_ff.ac_state == 2'h1;
      nxt_pins.dat[2] = sd_ff.ac_state == 2'h1;
      nxt_pins.oe_n[0] = sd_ff.ac_state[1];
      nxt_pins.oe_n[2] = sd_ff.ac_state[1];
      // RULE4 pair b/d drive state
      nxt_pins.dat[1] = sd_ff.bd_state == 2'h1;
      nxt_pins.dat[3] = sd_ff.bd_state == 2'h1;
      nxt_pins.oe_n[1] = sd_ff.bd_state[1];
      nxt_pins.oe_n[3] = sd_ff.bd_state[1];
    end
  end

  // RULE19 pins registered together with the flag
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pins_ff <= {4'h0, 4'hf};
    else
      pins_ff <= nxt_pins;
  end
  assign pwm_out = pins_ff.dat;
  assign pwm_out_oe_n = pins_ff.oe_n;
endmodule

module epoc_sync3 #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // raw pin and settled level
  input wire logic pin_in,
  output logic level
);
  logic [2:0] stage_ff;
  logic level_ff;
  wire agree = stage_ff[1] == stage_ff[2];

  // first flop may go metastable, so only stages 2 and 3 are compared
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      stage_ff <= {3{INIT}};
      level_ff <= INIT;
    end
    else
    begin
      stage_ff <= {stage_ff[1:0], pin_in};
      if (agree)
        level_ff <= stage_ff[2];
    end
  end
  assign level = level_ff;
endmodule

module epoc_tbsel (
  // select and candidate ticks
  input wire logic use_fourth,
  input wire logic second_tick,
  input wire logic fourth_tick,
  // chosen pwm time base
  output logic tick
);
  // third timer is never switched here; capture keeps it
  assign tick = use_fourth ? fourth_tick : second_tick;
endmodule

// File: sim/epoc_far.sv
// far side: period marks, timer ticks, fault and comparator levels
// assumes the bench requests levels on mclk; pwm_raw comes from the bench
`timescale 1ns/1ps
module epoc_far (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bench requests
  input wire logic fault_req,
  input wire logic [1:0] cmp_req,
  // towards the block
  output logic period_start,
  output logic second_timer_tick,
  output logic fourth_timer_tick,
  output logic fault_input_pin_n,
  output logic comparator1_output,
  output logic comparator2_output
);
  logic [3:0] cnt_ff;
  // short 16-cycle period keeps restart waits brief
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cnt_ff <= 4'h0;
      period_start <= 1'b0;
      second_timer_tick <= 1'b0;
      fourth_timer_tick <= 1'b0;
      fault_input_pin_n <= 1'b1;
      comparator1_output <= 1'b0;
      comparator2_output <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 4'h1;
      period_start <= cnt_ff == 4'hf;
      second_timer_tick <= cnt_ff[0];
      fourth_timer_tick <= cnt_ff[1:0] == 2'h3;
      fault_input_pin_n <= !fault_req;
      comparator1_output <= cmp_req[0];
      comparator2_output <= cmp_req[1];
    end
  end
endmodule

// File: sim/epoc_chk.sv
// checker for epoc_top: shutdown, restart and timebase select
// assumes binding to epoc_top; shadows registers from the write port
`timescale 1ns/1ps
module epoc_chk (
  // clock and reset
  input logic mclk,
  input logic reset,
  // register port
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  // timing and sources
  input logic period_start,
  input logic second_timer_tick,
  input logic fourth_timer_tick,
  input logic [2:0] pwm_timebase_tick,
  input logic fault_input_pin_n,
  input logic comparator1_output,
  input logic comparator2_output,
  // pins
  input logic [3:0] pwm_out,
  input logic [3:0] pwm_out_oe_n
);
  logic [7:0] sd_ff;
  logic [7:0] tb_ff;
  logic auto_ff;
  logic oe_a_ff;
  logic clr_ff;
  wire wr_sd = reg_wr && reg_addr == 8'h00;
  wire [3:0] sd_oe = {sd_ff[1], sd_ff[3], sd_ff[1], sd_ff[3]};
  wire [3:0] sd_dat = {sd_ff[0], sd_ff[2], sd_ff[0], sd_ff[2]};
  wire sd_match = pwm_out_oe_n == sd_oe && ((pwm_out ^ sd_dat) & ~sd_oe) == 4'h0;
  wire armed = sd_ff[6:4] != 3'h0 && sd_ff[3];
  wire [2:0] exp_tick = {tb_ff[6] ? fourth_timer_tick : second_timer_tick,
    tb_ff[3] ? fourth_timer_tick : second_timer_tick,
    tb_ff[0] ? fourth_timer_tick : second_timer_tick};
  // a clear counts only with the fault pin quiet; a new shutdown forgets it
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sd_ff <= 8'h00;
      tb_ff <= 8'h00;
      auto_ff <= 1'b0;
      oe_a_ff <= 1'b1;
      clr_ff <= 1'b0;
    end
    else
    begin
      if (wr_sd)
        sd_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h0c)
        tb_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h04)
        auto_ff <= reg_wdata[7];
      oe_a_ff <= pwm_out_oe_n[0];
      clr_ff <= (wr_sd && !reg_wdata[7] && fault_input_pin_n) ||
        (clr_ff && !(pwm_out_oe_n[0] && !oe_a_ff));
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_fault_shut: assert property ((!fault_input_pin_n)[*8] ##0 sd_ff[6] |-> sd_match)
    else $error("pins not shut under fault");
  a_cmp1_shut: assert property (comparator1_output[*8] ##0 sd_ff[4] |-> sd_match)
    else $error("pins not shut under comparator 1");
  a_cmp2_shut: assert property (comparator2_output[*8] ##0 sd_ff[5] |-> sd_match)
    else $error("pins not shut under comparator 2");
  // period mark moves the sequencer, pins follow one edge later
  a_resume_period: assert property ($fell(pwm_out_oe_n[0]) && armed |-> $past(period_start, 2))
    else $error("resume off period start");
  a_manual_hold: assert property ($fell(pwm_out_oe_n[0]) && armed && !auto_ff |-> clr_ff)
    else $error("resume without clear");
  a_flag_locked: assert property ((!fault_input_pin_n)[*8] ##0 (wr_sd && sd_ff[6] && !auto_ff) |=> sd_match[*4])
    else $error("flag write took effect under fault");
  a_tbase_mux: assert property (pwm_timebase_tick == exp_tick)
    else $error("wrong time base");
  a_tbase_read: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == (tb_ff & 8'h49))
    else $error("time base readback");
  c_shut: cover property ((!fault_input_pin_n)[*8] ##0 sd_match);
  c_resume: cover property ($fell(pwm_out_oe_n[0]) && armed);
  c_locked: cover property (wr_sd && !fault_input_pin_n && !auto_ff);
endmodule
bind epoc_top epoc_chk chk_u (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .period_start, .second_timer_tick, .fourth_timer_tick, .pwm_timebase_tick,
  .fault_input_pin_n, .comparator1_output, .comparator2_output, .pwm_out, .pwm_out_oe_n);

// File: sim/epoc_tb.sv
// bench for epoc_top: registers, steering, delay and shutdown
// assumes epoc_far supplies period marks, ticks and shutdown levels
`timescale 1ns/1ps
module epoc_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pwm_raw = 1'b0;
  logic fault_req = 1'b0;
  logic [1:0] cmp_req = 2'h0;
  logic [3:0] port_dat = 4'ha;
  logic [7:0] rdata, rd_s;
  logic [2:0] tick;
  logic [3:0] pout, oe_n, out_s, oe_s;
  logic ps, t2, t4, flt_n, c1, c2;
  int n_errors = 0;
  int checks = 0;
  always #4 mclk = ~mclk;
  // outputs sampled mid-cycle, away from the launching edge
  always @(negedge mclk)
  begin
    out_s = pout;
    oe_s = oe_n;
    rd_s = rdata;
  end
  epoc_far far_u (.mclk(mclk), .reset(reset), .fault_req(fault_req), .cmp_req(cmp_req),
    .period_start(ps), .second_timer_tick(t2), .fourth_timer_tick(t4),
    .fault_input_pin_n(flt_n), .comparator1_output(c1), .comparator2_output(c2));
  epoc_top dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .pwm_raw(pwm_raw),
    .period_start(ps), .second_timer_tick(t2), .fourth_timer_tick(t4),
    .pwm_timebase_tick(tick), .port_dat(port_dat), .fault_input_pin_n(flt_n),
    .comparator1_output(c1), .comparator2_output(c2), .pwm_out(pout), .pwm_out_oe_n(oe_n));
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(what, rd_s, exp);
  endtask
  task automatic t_regs();
    rd(8'h00, 8'h00, "shutdown reset");
    rd(8'h08, 8'h01, "steer reset");
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h00, "unmapped");
    wr(8'h08, 8'hff);
    rd(8'h08, 8'hdf, "steer reserved");
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h49, "timebase bits");
    wr(8'h0c, 8'h08);
  endtask
  task automatic t_pol();
    wr(8'h08, 8'h03);
    pwm_raw <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h10, 8'h0c + 8'(m));
      repeat (4) @(posedge mclk);
      chk("polarity", {4'h0, out_s}, {4'h0, port_dat[3:2], !m[0], !m[1]});
    end
    wr(8'h10, 8'h08);
    repeat (4) @(posedge mclk);
    chk("not pwm", {5'h00, out_s[3:1]}, {5'h00, port_dat[3:1]});
    pwm_raw <= 1'b0;
    wr(8'h10, 8'h4c);
    repeat (4) @(posedge mclk);
    chk("forward", {4'h0, out_s}, 8'h01);
    wr(8'h10, 8'hcc);
    repeat (4) @(posedge mclk);
    chk("reverse", {4'h0, out_s}, 8'h04);
    wr(8'h10, 8'h0c);
  endtask
  task automatic t_cmpl();
    logic [3:0] pm;
    for (int c = 1; c < 4; c++)
    begin
      pm = 4'h1 | (4'h1 << c);
      wr(8'h08, {2'(c), 6'h01});
      pwm_raw <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("pair high", {4'h0, out_s}, {4'h0, (port_dat & ~pm) | 4'h1});
      pwm_raw <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("pair low", {4'h0, out_s}, {4'h0, (port_dat & ~pm) | (pm & 4'he)});
    end
  endtask
  task automatic lag(input logic [6:0] d, output int n);
    pwm_raw <= 1'b0;
    wr(8'h04, {1'b0, d});
    repeat (4) @(posedge mclk);
    pwm_raw <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge mclk);
      if (out_s[0] === 1'b1)
        break;
    end
    if (n == 200)
    begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic t_delay();
    int n1;
    int n2;
    wr(8'h08, 8'h01);
    lag(7'h03, n1);
    lag(7'h0a, n2);
    chk("delay lag", 8'(n2 - n1), 8'h07);
    pwm_raw <= 1'b0;
    wr(8'h04, 8'h00);
  endtask
  task automatic t_src();
    logic hit;
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h03);
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 3; k++)
      begin
        hit = k == 0 ? s[2] : (k == 1 ? s[0] : s[1]);
        wr(8'h00, {1'b0, 3'(s), 4'h9});
        fault_req <= k == 0;
        cmp_req <= {k == 2, k == 1};
        repeat (8) @(posedge mclk);
        rd(8'h00, {hit, 3'(s), 4'h9}, "flag by source");
        fault_req <= 1'b0;
        cmp_req <= 2'h0;
        repeat (10) @(posedge mclk);
        rd(8'h00, {1'b0, 3'(s), 4'h9}, "auto clear");
      end
  endtask
  task automatic t_manual();
    int n;
    repeat (20) @(posedge mclk);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h49);
    fault_req <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("shut enables", {4'h0, oe_s}, 8'h05);
    chk("shut levels", {4'h0, out_s & 4'ha}, 8'h0a);
    wr(8'h00, 8'h49);
    rd(8'h00, 8'hc9, "flag locked");
    fault_req <= 1'b0;
    repeat (40) @(posedge mclk);
    rd(8'h00, 8'hc9, "manual hold");
    chk("still shut", {4'h0, oe_s}, 8'h05);
    wr(8'h00, 8'h49);
    for (n = 0; n < 40 && oe_s[0] !== 1'b0; n++)
      @(posedge mclk);
    chk("resumed", 8'(n < 40), 8'h01);
    if (n == 40)
      final_report();
    rd(8'h00, 8'h49, "flag cleared");
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_pol();
    t_cmpl();
    t_delay();
    t_src();
    t_manual();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule
